// >>> verilog/ebl_pkg.sv
// Shared constants and types for the external bus lane and burst bridge
package ebl_pkg;
    // Access size codes from the core
    localparam logic [1:0]  SZ_BYTE        = 2'h0;
    localparam logic [1:0]  SZ_HALF        = 2'h1;
    localparam logic [1:0]  SZ_THREE       = 2'h2;
    localparam logic [1:0]  SZ_WORD        = 2'h3;
    // All byte lanes off
    localparam logic [3:0]  BE_NONE        = 4'hF;
    // Address step between burst words
    localparam logic [31:0] WORD_STEP      = 32'h4;
    // Low nibble of a start address that turns a burst downward
    localparam logic [3:0]  BURST_DOWN_NIB = 4'hC;
    // Width of the beat counter
    localparam int unsigned BEAT_W         = 3;
    // Default longest burst in words
    localparam int unsigned MAX_BEATS      = 4;
    // Clock period and bus timeout
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned BUS_TIMEOUT_NS = 2560;
    localparam int unsigned BUS_TIMEOUT_CYC =
        BUS_TIMEOUT_NS / CLK_PERIOD_NS;
    // Bus sequencer states
    typedef enum logic [0:0]
    {
        ST_IDLE = 1'h0,
        ST_WAIT = 1'h1
    } ebl_state_t;
endpackage

// >>> verilog/ebl_lane_enc.sv
// Byte-lane enable encoder for one physical bus phase
`timescale 1ns/1ps
`default_nettype none
module ebl_lane_enc
(
    input  wire logic [1:0] off,
    input  wire logic [1:0] size,
    input  wire logic       mode16,
    input  wire logic       second,
    output logic      [3:0] be_n
);
    logic [2:0] n_bytes; // Bytes in the access
    logic [7:0] top_mask; // Upper lanes for n bytes
    logic [3:0] en; // Active-high lane enables

    // Lane selection, big-endian only: offset 0 is the top lane
    always_comb
    begin
        n_bytes  = {1'b0, size} + 3'h1;
        top_mask = 8'hF0 >> n_bytes;
        en       = 4'h0;
        if (!mode16)
        begin
            // Full width: bit 3 is D31..24, bit 0 is D7..0
            en = top_mask[3:0] >> off;
        end
        else if (size == ebl_pkg::SZ_BYTE)
        begin
            // One lane of the low halfword
            en = 4'h2 >> off[0];
        end
        else if (size == ebl_pkg::SZ_THREE && second)
        begin
            // Trailing byte of a three-byte split
            en = 4'h2 >> off[0];
        end
        else
        begin
            // Halfword, or a full halfword phase of a split
            en = 4'h3;
        end
        be_n = ~en;
    end
endmodule
`default_nettype wire

// >>> verilog/ebl_bridge.sv
// External bus bridge: byte lanes, 16-bit split, burst, timeout, errors
// What this block does
// - Full width byte access enables one lane
// - Narrow bus byte uses lane 0 or 1
// - Halfword lanes 0011/1100 wide, 1100 narrow
// - Wide three-byte access: one cycle, 0001/1000
// - Narrow three-byte: two cycles, 1100 then 1101/1110
// - Wide word access: one cycle, all lanes
// - Narrow word: two cycles, both 1100
// - Big-endian byte order only
// - Master gives first address, bridge makes rest
// - Start nibble 0: burst steps up by four
// - Start nibble C: burst steps down by four
// - Write timeout raises non-maskable interrupt
// - Lane bit 3 is top byte, 0 bottom
// - Narrow bus uses low sixteen data lines
// - Cycle start strobe in first clock
`timescale 1ns/1ps
`default_nettype none
module ebl_bridge
#(
    parameter int unsigned TIMEOUT_CYC = ebl_pkg::BUS_TIMEOUT_CYC,
    parameter int unsigned MAX_BEATS   = ebl_pkg::MAX_BEATS
)
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        bus16_mode,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [31:0] req_addr,
    input  wire logic [1:0]  req_size,
    input  wire logic        req_write,
    input  wire logic [31:0] req_wdata,
    input  wire logic [2:0]  req_beats,
    output logic             rsp_valid,
    output logic      [31:0] rsp_rdata,
    output logic             rsp_error,
    input  wire logic        err_flag_clr,
    output logic             write_error_flag,
    output logic             nmi_req,
    output logic      [31:0] bus_addr,
    output logic      [3:0]  byte_lane_enable_n,
    output logic             bus_rw_n,
    output logic             cycle_begin_n,
    output logic             bus_last_n,
    output logic      [31:0] bus_data_o,
    output logic      [1:0]  bus_data_oe,
    input  wire logic [31:0] bus_data_i,
    input  wire logic        ack_n,
    input  wire logic        bus_error_n
);
    // Refuse settings the counters cannot hold
    if (MAX_BEATS < 1 || MAX_BEATS > 7 || TIMEOUT_CYC < 2
        || TIMEOUT_CYC > 65535)
    begin : g_bad_param
        $error("ebl_bridge: parameter out of range");
    end

    // Pin synchronisers, bit 1 bus error, bit 0 acknowledge
    logic [1:0]  sy1_q, sy2_q, sy3_q; // Three-stage chain
    logic [1:0]  filt_q, filt_d; // Agreed level
    logic [1:0]  prev_q; // Filtered level one clock back
    logic [31:0] din1_q, din2_q, din3_q; // Read data, same depth

    // Filter takes a change once stages two and three agree
    always_comb
    begin
        filt_d = filt_q;
        for (int i = 0; i < 2; i++)
        begin
            if (sy2_q[i] == sy3_q[i])
            begin
                filt_d[i] = sy3_q[i];
            end
        end
    end

    // Synchroniser registers, strobes idle high, read data resets to zero
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sy1_q  <= 2'h3;
            sy2_q  <= 2'h3;
            sy3_q  <= 2'h3;
            filt_q <= 2'h3;
            prev_q <= 2'h3;
            din1_q <= 32'h0;
            din2_q <= 32'h0;
            din3_q <= 32'h0;
        end
        else
        begin
            sy1_q  <= {bus_error_n, ack_n};
            sy2_q  <= sy1_q;
            sy3_q  <= sy2_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
            din1_q <= bus_data_i;
            din2_q <= din1_q;
            din3_q <= din2_q;
        end
    end

    // Sequencer state
    ebl_pkg::ebl_state_t state_q, state_d; // Bus phase state
    logic        mode16_q, mode16_d; // Bus width taken at request
    logic [1:0]  size_q, size_d; // Access size
    logic        write_q, write_d; // Direction
    logic [31:0] wdata_q, wdata_d; // Write data, lane aligned
    logic [31:0] addr_q, addr_d; // Current word address
    logic        half_q, half_d; // Second narrow phase
    logic        down_q, down_d; // Burst steps downward
    logic [2:0]  beats_q, beats_d; // Words still to move
    logic [15:0] to_cnt_q, to_cnt_d; // Cycles waiting for answer
    logic [31:0] baddr_q, baddr_d; // Bus address pins
    logic [3:0]  be_q, be_d; // Lane enable pins
    logic        rw_q, rw_d; // Read high, write low
    logic        beg_q, beg_d; // Start strobe
    logic        last_q, last_d; // Last phase strobe
    logic [31:0] dout_q, dout_d; // Write data pins
    logic [1:0]  oe_q, oe_d; // Halfword drive enables
    logic        rv_q, rv_d; // Answer pulse
    logic [31:0] rdata_q, rdata_d; // Assembled read data
    logic        rerr_q, rerr_d; // Answer carries an error
    logic        flag_q, flag_d; // Sticky read error flag
    logic        nmi_q, nmi_d; // Write timeout pulse

    // Encoder inputs for the phase about to be driven
    logic [1:0]  enc_off, enc_size;
    logic        enc_mode, enc_second;
    logic [3:0]  enc_be_n; // Encoded lanes
    logic        split; // Access needs two narrow phases
    logic        ack_edge, err_edge; // Responder events
    logic        timeout; // Wait has run out
    logic        use_lo; // Next phase carries the low halfword
    logic        cur_lo; // Current phase carries the low halfword
    logic        end_beat; // Current word completes
    logic [2:0]  nb; // Beats of a new request

    ebl_lane_enc u_lane_enc
    (
        .off    (enc_off),
        .size   (enc_size),
        .mode16 (enc_mode),
        .second (enc_second),
        .be_n   (enc_be_n)
    );

    // Events and encoder steering
    always_comb
    begin
        split      = mode16_q && size_q[1];
        ack_edge   = !filt_q[0] && prev_q[0];
        err_edge   = !filt_q[1] && prev_q[1];
        timeout    = to_cnt_q == 16'(TIMEOUT_CYC - 1);
        enc_off    = (state_q == ebl_pkg::ST_IDLE) ? req_addr[1:0]
                                                   : addr_q[1:0];
        enc_size   = (state_q == ebl_pkg::ST_IDLE) ? req_size : size_q;
        enc_mode   = (state_q == ebl_pkg::ST_IDLE) ? bus16_mode : mode16_q;
        enc_second = (state_q == ebl_pkg::ST_WAIT) && split && !half_q;
        use_lo     = enc_second || (!enc_size[1] && enc_off[1]);
        cur_lo     = half_q || (!split && addr_q[1]);
        end_beat   = !split || half_q;
        nb         = 3'h1;
        if (req_size == ebl_pkg::SZ_WORD && !req_write && req_beats != 3'h0)
        begin
            // Read bursts only; clamp to the longest allowed
            nb = (req_beats > 3'(MAX_BEATS)) ? 3'(MAX_BEATS) : req_beats;
        end
        req_ready = state_q == ebl_pkg::ST_IDLE;
    end

    // Next values of the sequencer
    always_comb
    begin
        state_d  = state_q;
        mode16_d = mode16_q;
        size_d   = size_q;
        write_d  = write_q;
        wdata_d  = wdata_q;
        addr_d   = addr_q;
        half_d   = half_q;
        down_d   = down_q;
        beats_d  = beats_q;
        to_cnt_d = to_cnt_q;
        baddr_d  = baddr_q;
        be_d     = be_q;
        rw_d     = rw_q;
        beg_d    = 1'b1;
        last_d   = last_q;
        dout_d   = dout_q;
        oe_d     = oe_q;
        rv_d     = 1'b0;
        rdata_d  = rdata_q;
        rerr_d   = 1'b0;
        flag_d   = flag_q && !err_flag_clr;
        nmi_d    = 1'b0;
        case (state_q)
            ebl_pkg::ST_IDLE:
            begin
                if (req_valid)
                begin
                    // Only the first address comes from the master
                    state_d  = ebl_pkg::ST_WAIT;
                    mode16_d = bus16_mode;
                    size_d   = req_size;
                    write_d  = req_write;
                    wdata_d  = req_wdata;
                    addr_d   = req_addr;
                    baddr_d  = req_addr;
                    half_d   = 1'b0;
                    down_d   = req_addr[3:0] == ebl_pkg::BURST_DOWN_NIB;
                    beats_d  = nb;
                    to_cnt_d = 16'h0;
                    be_d     = enc_be_n;
                    rw_d     = !req_write;
                    beg_d    = 1'b0;
                    last_d   = !(nb == 3'h1 && !(bus16_mode && req_size[1]));
                    // Narrow bus drives low lines only
                    dout_d   = bus16_mode ? {16'h0, use_lo ? req_wdata[15:0]
                                                    : req_wdata[31:16]}
                                          : req_wdata;
                    oe_d     = !req_write ? 2'h0 : bus16_mode ? 2'h1 : 2'h3;
                    rdata_d  = 32'h0;
                end
            end
            ebl_pkg::ST_WAIT:
            begin
                to_cnt_d = to_cnt_q + 16'h1;
                if (ack_edge)
                begin
                    // Gather read data into its halfword
                    if (!mode16_q)
                    begin
                        rdata_d = din3_q;
                    end
                    else if (cur_lo)
                    begin
                        rdata_d[15:0] = din3_q[15:0];
                    end
                    else
                    begin
                        rdata_d[31:16] = din3_q[15:0];
                    end
                    to_cnt_d = 16'h0;
                    rv_d     = end_beat && !write_q;
                    if (!end_beat)
                    begin
                        // Second narrow phase, low halfword
                        half_d  = 1'b1;
                        baddr_d = {addr_q[31:2], 2'b10};
                        be_d    = enc_be_n;
                        last_d  = beats_q != 3'h1;
                        dout_d  = {16'h0, wdata_q[15:0]};
                    end
                    else if (beats_q != 3'h1)
                    begin
                        // Next burst word, address made here
                        addr_d  = down_q ? addr_q - ebl_pkg::WORD_STEP
                                         : addr_q + ebl_pkg::WORD_STEP;
                        baddr_d = addr_d;
                        half_d  = 1'b0;
                        beats_d = beats_q - 3'h1;
                        be_d    = enc_be_n;
                        last_d  = !(beats_q == 3'h2 && !split);
                    end
                    else
                    begin
                        // Operation complete, release the bus
                        rv_d    = 1'b1;
                        state_d = ebl_pkg::ST_IDLE;
                    end
                end
                else if ((err_edge && !write_q) || timeout)
                begin
                    // Bus error on writes is never raised
                    rv_d    = 1'b1;
                    rerr_d  = 1'b1;
                    nmi_d   = timeout && write_q;
                    state_d = ebl_pkg::ST_IDLE;
                    if (!write_q)
                    begin
                        flag_d = 1'b1;
                    end
                end
                if (state_d == ebl_pkg::ST_IDLE)
                begin
                    be_d   = ebl_pkg::BE_NONE;
                    rw_d   = 1'b1;
                    last_d = 1'b1;
                    oe_d   = 2'h0;
                end
            end
            default:
            begin
                state_d = ebl_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q  <= ebl_pkg::ST_IDLE;
            mode16_q <= 1'b0;
            size_q   <= ebl_pkg::SZ_BYTE;
            write_q  <= 1'b0;
            wdata_q  <= 32'h0;
            addr_q   <= 32'h0;
            half_q   <= 1'b0;
            down_q   <= 1'b0;
            beats_q  <= 3'h0;
            to_cnt_q <= 16'h0;
            baddr_q  <= 32'h0;
            be_q     <= ebl_pkg::BE_NONE;
            rw_q     <= 1'b1;
            beg_q    <= 1'b1;
            last_q   <= 1'b1;
            dout_q   <= 32'h0;
            oe_q     <= 2'h0;
            rv_q     <= 1'b0;
            rdata_q  <= 32'h0;
            rerr_q   <= 1'b0;
            flag_q   <= 1'b0;
            nmi_q    <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            mode16_q <= mode16_d;
            size_q   <= size_d;
            write_q  <= write_d;
            wdata_q  <= wdata_d;
            addr_q   <= addr_d;
            half_q   <= half_d;
            down_q   <= down_d;
            beats_q  <= beats_d;
            to_cnt_q <= to_cnt_d;
            baddr_q  <= baddr_d;
            be_q     <= be_d;
            rw_q     <= rw_d;
            beg_q    <= beg_d;
            last_q   <= last_d;
            dout_q   <= dout_d;
            oe_q     <= oe_d;
            rv_q     <= rv_d;
            rdata_q  <= rdata_d;
            rerr_q   <= rerr_d;
            flag_q   <= flag_d;
            nmi_q    <= nmi_d;
        end
    end

    // Output pins and answers
    assign rsp_valid          = rv_q;
    assign rsp_rdata          = rdata_q;
    assign rsp_error          = rerr_q;
    assign write_error_flag   = flag_q;
    assign nmi_req            = nmi_q;
    assign bus_addr           = baddr_q;
    assign byte_lane_enable_n = be_q;
    assign bus_rw_n           = rw_q;
    assign cycle_begin_n      = beg_q;
    assign bus_last_n         = last_q;
    assign bus_data_o         = dout_q;
    assign bus_data_oe        = oe_q;

    // Checks on the driven bus
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_byte_lane_wide: assert property (
        (!beg_q && !mode16_q && size_q == ebl_pkg::SZ_BYTE)
        |-> be_q inside {4'h7, 4'hB, 4'hD, 4'hE})
        else $error("wide byte access has a bad lane pattern");
    chk_byte_lane_narrow: assert property (
        (state_q == ebl_pkg::ST_WAIT && mode16_q
         && size_q == ebl_pkg::SZ_BYTE) |-> be_q inside {4'hD, 4'hE})
        else $error("narrow byte access has a bad lane pattern");
    chk_half_lanes: assert property (
        (state_q == ebl_pkg::ST_WAIT && size_q == ebl_pkg::SZ_HALF)
        |-> (mode16_q ? be_q == 4'hC : be_q inside {4'h3, 4'hC}))
        else $error("halfword access has a bad lane pattern");
    chk_three_single: assert property (
        (!beg_q && !mode16_q && size_q == ebl_pkg::SZ_THREE)
        |-> !last_q && be_q inside {4'h1, 4'h8})
        else $error("wide three-byte access is not one cycle");
    chk_three_split: assert property (
        (!beg_q && mode16_q && size_q == ebl_pkg::SZ_THREE)
        |-> be_q == 4'hC && last_q)
        else $error("narrow three-byte first phase is wrong");
    chk_word_wide: assert property (
        (!beg_q && !mode16_q && size_q == ebl_pkg::SZ_WORD)
        |-> be_q == 4'h0)
        else $error("wide word access lacks all lanes");
    chk_word_split: assert property (
        (state_q == ebl_pkg::ST_WAIT && mode16_q
         && size_q == ebl_pkg::SZ_WORD) |-> be_q == 4'hC)
        else $error("narrow word phase lanes are not 1100");
    chk_burst_up: assert property (
        (state_q == ebl_pkg::ST_WAIT && $past(state_q) == ebl_pkg::ST_WAIT
         && $changed(addr_q) && !down_q)
        |-> addr_q == $past(addr_q) + 32'h4)
        else $error("upward burst did not step by four");
    chk_burst_down: assert property (
        (state_q == ebl_pkg::ST_WAIT && $past(state_q) == ebl_pkg::ST_WAIT
         && $changed(addr_q) && down_q)
        |-> addr_q == $past(addr_q) - 32'h4)
        else $error("downward burst did not step by four");
    chk_nmi_write: assert property (
        (state_q == ebl_pkg::ST_WAIT && timeout && write_q && !ack_edge)
        |=> nmi_q ##1 !nmi_q)
        else $error("write timeout did not pulse the interrupt");
    chk_begin_first: assert property (
        (req_valid && req_ready) |=> !cycle_begin_n ##1 cycle_begin_n)
        else $error("start strobe not in first clock only");
    chk_upper_quiet: assert property (
        (state_q == ebl_pkg::ST_WAIT && mode16_q) |-> !bus_data_oe[1])
        else $error("narrow bus drives upper data lines");

    cov_burst_down: cover property (
        (!beg_q && down_q && beats_q == 3'h4) ##[1:200] rv_q);
    cov_narrow_word_write: cover property (
        (!beg_q && mode16_q && write_q && size_q == ebl_pkg::SZ_WORD)
        ##[1:200] half_q);
    cov_write_timeout: cover property (nmi_q);
endmodule
`default_nettype wire

// >>> dv/ebl_bus_model.sv
// Behavioural responder standing on the far side of the bus bridge
`timescale 1ns/1ps
`default_nettype none
module ebl_bus_model
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [31:0] bus_addr,
    input  wire logic [3:0]  be_n,
    input  wire logic        rw_n,
    input  wire logic        begin_n,
    input  wire logic [3:0]  delay,
    input  wire logic        mute,
    input  wire logic        err_on,
    output logic             ack_n,
    output logic             bus_error_n,
    output logic      [31:0] data
);
    logic [3:0]  cnt_q;   // Wait, hold and rest counter
    logic        fresh_q; // A phase is waiting for an answer
    logic [35:0] sig_q;   // Address and lanes seen last cycle

    // Answer each phase once; strobe rests high between answers
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {cnt_q, fresh_q, ack_n, bus_error_n} <= 7'h03;
            sig_q <= {32'h0, 4'hF};
            data  <= 32'h0;
        end
        else
        begin
            sig_q <= {bus_addr, be_n};
            // Read data from the address; inverted when not read
            data <= (be_n != 4'hF && rw_n) ?
                    {~bus_addr[15:0], bus_addr[15:0]} : ~data;
            if (!begin_n || (be_n != 4'hF && {bus_addr, be_n} != sig_q))
                fresh_q <= 1'b1;
            if (ack_n && bus_error_n)
            begin
                if (fresh_q && be_n != 4'hF && !mute)
                begin
                    if (cnt_q == delay + 4'h4)
                    begin
                        cnt_q   <= 4'h0;
                        fresh_q <= 1'b0;
                        if (err_on && rw_n)
                            bus_error_n <= 1'b0;
                        else
                            ack_n <= 1'b0;
                    end
                    else
                        cnt_q <= cnt_q + 4'h1;
                end
            end
            else if (cnt_q == 4'h5)
            begin
                // Release after the filter has seen the edge
                {cnt_q, ack_n, bus_error_n} <= 6'h03;
            end
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> dv/ext_bus_byte_lane_burst_bench.sv
// Self-checking bench for the external bus bridge
`timescale 1ns/1ps
`default_nettype none
module ext_bus_byte_lane_burst_bench;
    logic        core_clk, nrst, m16, rv, wr, clr, mute, eon, rdy, rsv;
    logic        rer, flg, nmi, rwn, bgn, lst, ack_n, ber_n;
    logic [1:0]  sz, oe;
    logic [2:0]  bt;
    logic [3:0]  be, dly;
    logic [31:0] ad, wd, rd, ba, dout, din;
    logic [35:0] sig;   // Last lanes and address seen
    logic [35:0] ph[$]; // Phase log
    logic [35:0] rq[$]; // Response log
    logic [35:0] dq[$]; // Direction, last, enables and write data
    int          err_total, n_tests, nbeg, nnmi, k;

    ebl_bridge #(.TIMEOUT_CYC(24), .MAX_BEATS(4)) ebl_bridge_inst
    (
        .core_clk(core_clk), .nrst(nrst), .bus16_mode(m16),
        .req_valid(rv), .req_ready(rdy), .req_addr(ad), .req_size(sz),
        .req_write(wr), .req_wdata(wd), .req_beats(bt), .rsp_valid(rsv),
        .rsp_rdata(rd), .rsp_error(rer), .err_flag_clr(clr),
        .write_error_flag(flg), .nmi_req(nmi), .bus_addr(ba),
        .byte_lane_enable_n(be), .bus_rw_n(rwn), .cycle_begin_n(bgn),
        .bus_last_n(lst), .bus_data_o(dout), .bus_data_oe(oe),
        .bus_data_i(din), .ack_n(ack_n), .bus_error_n(ber_n)
    );
    ebl_bus_model ebl_bus_model_inst
    (
        .core_clk(core_clk), .nrst(nrst), .bus_addr(ba), .be_n(be),
        .rw_n(rwn), .begin_n(bgn), .delay(dly), .mute(mute),
        .err_on(eon), .ack_n(ack_n), .bus_error_n(ber_n), .data(din)
    );

    // Free running clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Log phases, write data, strobes and responses
    always @(negedge core_clk)
    begin
        if (be != 4'hF && {ba, be} != sig)
        begin
            ph.push_back({ba, be});
            dq.push_back({rwn, lst, oe, dout});
        end
        sig = {ba, be};
        if (!bgn) nbeg++;
        if (nmi) nnmi++;
        if (rsv) rq.push_back({3'h0, rer, rd});
    end

    task automatic print_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One core request, waiting for n responses
    task automatic op(input logic m, input logic [31:0] a,
        input logic [1:0] s, input logic w, input logic [2:0] b, input int n);
        {nbeg, nnmi} = 0;
        ph.delete();
        dq.delete();
        rq.delete();
        @(negedge core_clk);
        chk({35'h0, rdy}, 36'h1);
        {m16, ad, sz, wr, bt, rv} = {m, a, s, w, b, 1'b1};
        @(negedge core_clk);
        rv = 1'b0;
        for (k = 0; k < 300 && rq.size() < n; k++)
            @(negedge core_clk);
        repeat (6) @(negedge core_clk);
        if (rq.size() != n)
        begin
            chk(36'(rq.size()), 36'(n));
            print_verdict();
        end
        chk(36'(nbeg), 36'h1);
    endtask

    // Lane patterns for every size and width, at offsets 0 to 3 for wide bytes only
    task automatic lanes;
        logic [19:0] t [15] = '{20'h0007F, 20'h010BF, 20'h020DF,
            20'h030EF, 20'h0013F, 20'h021CF, 20'h0021F, 20'h0128F,
            20'h0030F, 20'h100DF, 20'h110EF, 20'h101CF, 20'h102CD,
            20'h112CE, 20'h103CC};
        foreach (t[i])
        begin
            op(t[i][16], 32'h200 | t[i][15:12], t[i][9:8], 1'b0, 3'h0, 1);
            chk({32'h0, ph[0][3:0]}, {32'h0, t[i][7:4]});
            chk(36'(ph.size()), (t[i][3:0] == 4'hF) ? 36'h1 : 36'h2);
            if (t[i][3:0] != 4'hF)
                chk(ph[1], {32'h202, t[i][3:0]});
        end
    endtask

    // Data placement and halfword order
    task automatic datapath;
        wd = 32'h1234_5678;
        op(1'b1, 32'h300, 2'h3, 1'b1, 3'h0, 1);
        chk(dq[0], {4'h5, 32'h1234});
        chk(dq[1], {4'h1, 32'h5678});
        op(1'b0, 32'h304, 2'h3, 1'b1, 3'h0, 1);
        chk(dq[0], {4'h3, wd});
        op(1'b0, 32'h400, 2'h3, 1'b0, 3'h0, 1);
        chk(rq[0], {4'h0, 32'hFBFF_0400});
        dly = 4'h4;
        op(1'b1, 32'h500, 2'h3, 1'b0, 3'h0, 1);
        chk(rq[0], {4'h0, 32'h0500_0502});
        dly = 4'h0;
    endtask

    // Four-word read burst from one start address
    task automatic burst(input logic [31:0] a, input logic [31:0] st);
        logic [31:0] x;
        op(1'b0, a, 2'h3, 1'b0, 3'h4, 4);
        for (int i = 0; i < 4; i++)
        begin
            x = a + st * 32'(i);
            chk(ph[i], {x, 4'h0});
            chk(rq[i], {4'h0, ~x[15:0], x[15:0]});
            chk({34'h0, dq[i][35:34]}, {34'h0, 1'b1, i != 3});
        end
    endtask

    // Timeouts, bus errors and flag clearing
    task automatic faults;
        mute = 1'b1;
        op(1'b0, 32'h600, 2'h3, 1'b1, 3'h0, 1);
        chk({rq[0][32], flg, 34'(nnmi)}, {2'b10, 34'h1});
        op(1'b0, 32'h604, 2'h3, 1'b0, 3'h0, 1);
        chk({rq[0][32], flg, 34'(nnmi)}, {2'b11, 34'h0});
        mute = 1'b0;
        clr = 1'b1;
        @(negedge core_clk);
        clr = 1'b0;
        @(negedge core_clk);
        chk({35'h0, flg}, 36'h0);
        eon = 1'b1;
        op(1'b0, 32'h608, 2'h3, 1'b0, 3'h0, 1);
        chk({rq[0][32], flg, 34'(nnmi)}, {2'b11, 34'h0});
        op(1'b0, 32'h60C, 2'h3, 1'b1, 3'h0, 1);
        chk({rq[0][32], flg, 34'(nnmi)}, {2'b01, 34'h0});
        eon = 1'b0;
    endtask

    // Main sequence
    initial
    begin
        {nrst, m16, rv, wr, clr, mute, eon, sz, bt, dly, ad, wd} = '0;
        {err_total, n_tests} = 0;
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        chk({25'h0, be, rwn, bgn, lst, oe, rsv, flg}, {25'h0, 11'h7F0});
        lanes();
        datapath();
        burst(32'h100, 32'h4);
        burst(32'h10C, 32'hFFFF_FFFC);
        faults();
        print_verdict();
    end
endmodule
`default_nettype wire
